// [verilog/sltc_pkg.sv]
// constants, types and register map of the serial link transmit control block
package sltc_pkg;

   localparam int          ADDR_W              = 12;
   localparam int          DATA_W              = 8;
   localparam int          MODE_W              = 6;
   localparam int          KEFF_W              = 12;

   localparam logic [11:0] OFFS_TS_LSB_CTRL    = 12'h160;
   localparam logic [11:0] OFFS_LINK_ENABLE    = 12'h200;
   localparam logic [11:0] OFFS_OUTPUT_MODE    = 12'h201;
   localparam logic [11:0] OFFS_FRAMES_PER_MF  = 12'h202;
   localparam logic [11:0] OFFS_SW_SYNC        = 12'h203;
   localparam logic [11:0] OFFS_SYNC_CTRL      = 12'h2f0;

   localparam int          BIT_TS_LSB_EN       = 0;
   localparam int          BIT_LINK_EN         = 0;
   localparam int          BIT_SW_SYNC_N       = 0;
   localparam int          BIT_SYNC_SEL_LO     = 0;
   localparam int          BIT_TS_RECV_EN      = 2;

   localparam logic        RST_TS_LSB_EN       = 1'b0;
   localparam logic        RST_LINK_EN         = 1'b1;
   localparam logic [5:0]  RST_OUTPUT_MODE     = 6'h00;
   localparam logic [7:0]  RST_FRAMES_MINUS1   = 8'h1f;
   localparam logic        RST_SW_SYNC_N       = 1'b1;
   localparam logic        RST_TS_RECV_EN      = 1'b0;
   localparam logic [7:0]  RST_READ_DATA       = 8'h00;

   localparam logic [1:0]  ILA_CS_VALUE        = 2'h0;
   localparam int          SYNC_STAGES         = 2;
   localparam int          TS_DELAY_CYCLES     = 4;
   localparam logic [8:0]  EMB_FRAMES_SCALE    = 9'h100;

   typedef enum logic [1:0] {
      SYNC_SRC_DEDICATED = 2'h0,
      SYNC_SRC_TIMESTAMP = 2'h1,
      SYNC_SRC_SOFTWARE  = 2'h2,
      SYNC_SRC_RESERVED  = 2'h3
   } sltc_sync_sel_e;

   typedef struct packed {
      logic link_reset_b;
      logic serializer_power_down;
      logic link_clock_enable;
      logic multiframe_counter_reset;
   } sltc_link_ctrl_s;

   typedef struct packed {
      logic [11:0] addr;
      logic [7:0]  wdata;
      logic        write;
      logic        read;
   } sltc_reg_req_s;

endpackage

// [verilog/sltc_sync2.sv]
// two-flop synchroniser for pin levels
`timescale 1ns/1ps
module sltc_sync2 #(
   parameter int WIDTH = 1
) (
   input  wire logic             sys_clk_in,
   input  wire logic             rst_b_in,
   input  wire logic [WIDTH-1:0] rst_value_in,
   input  wire logic [WIDTH-1:0] async_in,
   output logic      [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] meta_reg;
   logic [WIDTH-1:0] sync_reg;

   initial begin
      if (WIDTH < 1) $error("sltc_sync2: WIDTH must be at least 1");
   end

   // only the second stage is read outside
   always_ff @(posedge sys_clk_in) begin
      if (!rst_b_in) begin
         meta_reg <= rst_value_in;
         sync_reg <= rst_value_in;
      end else begin
         meta_reg <= async_in;
         sync_reg <= meta_reg;
      end
   end

   assign sync_out = sync_reg;
endmodule

// [verilog/sltc_delay_line.sv]
// fixed delay line, registered output
`timescale 1ns/1ps
module sltc_delay_line #(
   parameter int WIDTH = 1,
   parameter int DEPTH = 4
) (
   input  wire logic             sys_clk_in,
   input  wire logic             rst_b_in,
   input  wire logic [WIDTH-1:0] data_in,
   output logic      [WIDTH-1:0] data_out
);
   logic [WIDTH-1:0] stage_reg  [DEPTH];
   logic [WIDTH-1:0] stage_next [DEPTH];

   initial begin
      if (WIDTH < 1 || DEPTH < 1) $error("sltc_delay_line: WIDTH and DEPTH must be >= 1");
   end

   always_comb begin
      stage_next[0] = data_in;
      for (int i = 1; i < DEPTH; i++) begin
         stage_next[i] = stage_reg[i-1];
      end
   end

   always_ff @(posedge sys_clk_in) begin
      for (int i = 0; i < DEPTH; i++) begin
         if (!rst_b_in) begin
            stage_reg[i] <= '0;
         end else begin
            stage_reg[i] <= stage_next[i];
         end
      end
   end

   assign data_out = stage_reg[DEPTH-1];
endmodule

// [verilog/sltc_regs.sv]
// serial link transmit control registers with sample timestamp and sync request
//
// Local design decision: the strobed register port.
`timescale 1ns/1ps
module sltc_regs
   import sltc_pkg::*;
#(
   parameter int CONV_W   = 12,
   parameter int LINK_W   = 16,
   parameter int TS_DELAY = TS_DELAY_CYCLES
) (
   input  wire logic                 sys_clk_in,
   input  wire logic                 rst_b_in,
   // register port
   input  wire logic [ADDR_W-1:0]    reg_addr_in,
   input  wire logic [DATA_W-1:0]    reg_wdata_in,
   input  wire logic                 reg_write_in,
   input  wire logic                 reg_read_in,
   output logic      [DATA_W-1:0]    reg_rdata_out,
   // from calibration and mode table logic, same clock
   input  wire logic                 calibration_enable_in,
   input  wire logic                 mode_is_64b66b_in,
   input  wire logic [3:0]           mode_e_in,
   input  wire logic [4:0]           mode_f_in,
   // pins
   input  wire logic                 dedicated_sync_input_n_in,
   input  wire logic                 timestamp_input_pins_in,
   input  wire logic                 sysref_in,
   // converter samples, same clock
   input  wire logic                 sample_valid_in,
   input  wire logic [CONV_W-1:0]    sample_data_in,
   // link side
   output logic                      link_sample_valid_out,
   output logic      [LINK_W-1:0]    link_sample_data_out,
   output logic                      serial_link_enable_out,
   output sltc_link_ctrl_s           link_ctrl_out,
   output logic                      sysref_align_out,
   output logic      [MODE_W-1:0]    output_mode_select_out,
   output logic      [KEFF_W-1:0]    frames_per_multiframe_out,
   output logic      [1:0]           ila_control_bits_out,
   output logic                      sync_request_out
);

   ////////////////////////////////////////////////////////////////////////////
   // parameter checks and helpers

   initial begin
      if (CONV_W < 2 || LINK_W < CONV_W) $error("sltc_regs: need 2 <= CONV_W <= LINK_W");
      if (TS_DELAY < 1) $error("sltc_regs: TS_DELAY must be at least 1");
   end

   // effective frames per multiframe in 64b/66b modes
   function automatic logic [KEFF_W-1:0] emb_frames(input logic [3:0] e, input logic [4:0] f);
      logic [12:0] prod;
      prod = 13'(EMB_FRAMES_SCALE) * 13'(e);
      if (f == 5'h00) begin
         emb_frames = '0;
      end else begin
         emb_frames = KEFF_W'(prod / 13'(f));
      end
   endfunction

   function automatic logic addr_hit(input logic [ADDR_W-1:0] a, input logic [11:0] offs);
      addr_hit = (a == offs);
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // register file

   logic                 ts_lsb_en_reg;
   logic                 ts_lsb_en_next;
   logic                 link_en_reg;
   logic                 link_en_next;
   logic [MODE_W-1:0]    mode_reg;
   logic [MODE_W-1:0]    mode_next;
   logic [7:0]           frames_m1_reg;
   logic [7:0]           frames_m1_next;
   logic                 sw_sync_n_reg;
   logic                 sw_sync_n_next;
   sltc_sync_sel_e       sync_sel_reg;
   sltc_sync_sel_e       sync_sel_next;
   logic                 ts_recv_en_reg;
   logic                 ts_recv_en_next;
   logic [DATA_W-1:0]    rdata_reg;
   logic [DATA_W-1:0]    rdata_next;
   sltc_reg_req_s        req;

   assign req = '{addr: reg_addr_in, wdata: reg_wdata_in, write: reg_write_in,
                  read: reg_read_in};

   // reserved bits are dropped on write, so they always read back zero
   always_comb begin
      ts_lsb_en_next  = ts_lsb_en_reg;
      link_en_next    = link_en_reg;
      mode_next       = mode_reg;
      frames_m1_next  = frames_m1_reg;
      sw_sync_n_next  = sw_sync_n_reg;
      sync_sel_next   = sync_sel_reg;
      ts_recv_en_next = ts_recv_en_reg;
      if (req.write) begin
         if (addr_hit(req.addr, OFFS_TS_LSB_CTRL)) begin
            ts_lsb_en_next = req.wdata[BIT_TS_LSB_EN];
         end
         if (addr_hit(req.addr, OFFS_LINK_ENABLE)) begin
            link_en_next = req.wdata[BIT_LINK_EN];
         end
         if (addr_hit(req.addr, OFFS_OUTPUT_MODE)) begin
            mode_next = req.wdata[MODE_W-1:0];
         end
         if (addr_hit(req.addr, OFFS_FRAMES_PER_MF)) begin
            frames_m1_next = req.wdata;
         end
         if (addr_hit(req.addr, OFFS_SW_SYNC)) begin
            sw_sync_n_next = req.wdata[BIT_SW_SYNC_N];
         end
         if (addr_hit(req.addr, OFFS_SYNC_CTRL)) begin
            sync_sel_next   = sltc_sync_sel_e'(req.wdata[BIT_SYNC_SEL_LO +: 2]);
            ts_recv_en_next = req.wdata[BIT_TS_RECV_EN];
         end
      end
   end

   // read data stand in the cycle after the strobe only
   always_comb begin
      rdata_next = RST_READ_DATA;
      if (req.read) begin
         if (addr_hit(req.addr, OFFS_TS_LSB_CTRL)) begin
            rdata_next = {7'h00, ts_lsb_en_reg};
         end else if (addr_hit(req.addr, OFFS_LINK_ENABLE)) begin
            rdata_next = {7'h00, link_en_reg};
         end else if (addr_hit(req.addr, OFFS_OUTPUT_MODE)) begin
            rdata_next = {2'h0, mode_reg};
         end else if (addr_hit(req.addr, OFFS_FRAMES_PER_MF)) begin
            rdata_next = frames_m1_reg;
         end else if (addr_hit(req.addr, OFFS_SW_SYNC)) begin
            rdata_next = {7'h00, sw_sync_n_reg};
         end else if (addr_hit(req.addr, OFFS_SYNC_CTRL)) begin
            rdata_next = {5'h00, ts_recv_en_reg, sync_sel_reg};
         end
      end
   end

   always_ff @(posedge sys_clk_in) begin
      if (!rst_b_in) begin
         ts_lsb_en_reg  <= RST_TS_LSB_EN;
         link_en_reg    <= RST_LINK_EN;
         mode_reg       <= RST_OUTPUT_MODE;
         frames_m1_reg  <= RST_FRAMES_MINUS1;
         sw_sync_n_reg  <= RST_SW_SYNC_N;
         sync_sel_reg   <= SYNC_SRC_DEDICATED;
         ts_recv_en_reg <= RST_TS_RECV_EN;
         rdata_reg      <= RST_READ_DATA;
      end else begin
         ts_lsb_en_reg  <= ts_lsb_en_next;
         link_en_reg    <= link_en_next;
         mode_reg       <= mode_next;
         frames_m1_reg  <= frames_m1_next;
         sw_sync_n_reg  <= sw_sync_n_next;
         sync_sel_reg   <= sync_sel_next;
         ts_recv_en_reg <= ts_recv_en_next;
         rdata_reg      <= rdata_next;
      end
   end

   assign reg_rdata_out = rdata_reg;

   ////////////////////////////////////////////////////////////////////////////
   // pin synchronisers

   logic [2:0] pins_sync;

   sltc_sync2 #(
      .WIDTH (3)
   ) u_pin_sync (
      .sys_clk_in   (sys_clk_in),
      .rst_b_in     (rst_b_in),
      // sysref idles low, both sync pins idle high (no request)
      .rst_value_in (3'h3),
      .async_in     ({sysref_in, timestamp_input_pins_in, dedicated_sync_input_n_in}),
      .sync_out     (pins_sync)
   );

   ////////////////////////////////////////////////////////////////////////////
   // link enable side effects

   // disabled link: reset, power down, gate clocks, hold multiframe counter in reset
   always_comb begin
      link_ctrl_out.link_reset_b             = link_en_reg;
      link_ctrl_out.serializer_power_down    = ~link_en_reg;
      link_ctrl_out.link_clock_enable        = link_en_reg;
      link_ctrl_out.multiframe_counter_reset = ~link_en_reg;
   end

   assign serial_link_enable_out = link_en_reg;
   // sysref cannot realign a counter that is held in reset
   assign sysref_align_out       = pins_sync[2] & link_en_reg;
   assign output_mode_select_out = mode_reg;

   ////////////////////////////////////////////////////////////////////////////
   // frames per multiframe

   logic [KEFF_W-1:0] kframes_reg;
   logic [KEFF_W-1:0] kframes_next;

   // the divider is registered to keep it off the mode change timing path
   always_comb begin
      if (mode_is_64b66b_in) begin
         kframes_next = emb_frames(mode_e_in, mode_f_in);
      end else begin
         kframes_next = KEFF_W'(frames_m1_reg) + KEFF_W'(1);
      end
   end

   always_ff @(posedge sys_clk_in) begin
      if (!rst_b_in) begin
         kframes_reg <= KEFF_W'(RST_FRAMES_MINUS1) + KEFF_W'(1);
      end else begin
         kframes_reg <= kframes_next;
      end
   end

   assign frames_per_multiframe_out = kframes_reg;

   ////////////////////////////////////////////////////////////////////////////
   // sync request

   logic sync_pin_low;

   // pin contributes only while selected; a stuck pin clears once any other select value is written
   always_comb begin
      unique case (sync_sel_reg)
         SYNC_SRC_DEDICATED: sync_pin_low = ~pins_sync[0];
         SYNC_SRC_TIMESTAMP: sync_pin_low = ~pins_sync[1];
         default:            sync_pin_low = 1'b0;
      endcase
   end

   assign sync_request_out = ~sw_sync_n_reg | sync_pin_low;

   ////////////////////////////////////////////////////////////////////////////
   // timestamp path and sample packing

   logic              ts_gated;
   logic              ts_delayed;
   logic              lvalid_reg;
   logic              lvalid_next;
   logic [LINK_W-1:0] ldata_reg;
   logic [LINK_W-1:0] ldata_next;

   // two sync stages plus the line give the sample path latency
   assign ts_gated = pins_sync[1] & ts_recv_en_reg;

   sltc_delay_line #(
      .WIDTH (1),
      .DEPTH (TS_DELAY)
   ) u_ts_delay (
      .sys_clk_in (sys_clk_in),
      .rst_b_in   (rst_b_in),
      .data_in    (ts_gated),
      .data_out   (ts_delayed)
   );

   // converter sample is left aligned; bit 0 belongs to the timestamp
   always_comb begin
      lvalid_next = sample_valid_in & link_en_reg;
      ldata_next  = LINK_W'(sample_data_in) << (LINK_W-CONV_W);
      if (ts_lsb_en_reg) begin
         ldata_next[0] = ts_delayed;
      end
      if (!link_en_reg) begin
         ldata_next = '0;
      end
   end

   always_ff @(posedge sys_clk_in) begin
      if (!rst_b_in) begin
         lvalid_reg <= 1'b0;
         ldata_reg  <= '0;
      end else begin
         lvalid_reg <= lvalid_next;
         ldata_reg  <= ldata_next;
      end
   end

   assign link_sample_valid_out = lvalid_reg;
   assign link_sample_data_out  = ldata_reg;
   assign ila_control_bits_out  = ILA_CS_VALUE;

   ////////////////////////////////////////////////////////////////////////////
   // checks

   default clocking cb @(posedge sys_clk_in); endclocking
   default disable iff (!rst_b_in);

   a_ts_lsb_carry:
      assert property (ts_lsb_en_reg && link_en_reg |=> link_sample_data_out[0] == $past(ts_delayed))
      else $error("timestamp not in sample lsb");
   a_conv_bits_kept:
      assert property (link_en_reg |=>
         link_sample_data_out[LINK_W-1 -: CONV_W-1] == $past(sample_data_in[CONV_W-1:1]))
      else $error("converter upper bits altered");
   a_ila_cs_zero:
      assert property (ila_control_bits_out == 2'h0)
      else $error("alignment control bits not zero");
   a_ts_latency:
      assert property ($past(ts_gated, TS_DELAY) |-> ts_delayed)
      else $error("timestamp delay wrong");
   a_link_en_write:
      assert property (req.write && addr_hit(req.addr, OFFS_LINK_ENABLE)
         |=> serial_link_enable_out == $past(req.wdata[0]))
      else $error("link enable write lost");
   a_link_off_fx:
      assert property (!link_en_reg |-> !link_ctrl_out.link_reset_b
         && link_ctrl_out.serializer_power_down && !link_ctrl_out.link_clock_enable)
      else $error("disabled link not held down");
   a_sysref_blocked:
      assert property (!link_en_reg |-> !sysref_align_out && link_ctrl_out.multiframe_counter_reset)
      else $error("sysref passed while link disabled");
   a_kframes_emb:
      assert property (mode_is_64b66b_in && mode_f_in != 5'h00
         |=> frames_per_multiframe_out == KEFF_W'((13'h100 * $past(mode_e_in)) / $past(mode_f_in)))
      else $error("64b66b frame count wrong");
   a_kframes_km1:
      assert property (!mode_is_64b66b_in |=> frames_per_multiframe_out
         == KEFF_W'($past(frames_m1_reg)) + KEFF_W'(1))
      else $error("frame count not length plus one");
   a_sw_sync_req:
      assert property (!sw_sync_n_reg |-> sync_request_out)
      else $error("software sync not requested");
   a_sync_sel_sw:
      assert property (sync_sel_reg == SYNC_SRC_SOFTWARE && sw_sync_n_reg |-> !sync_request_out)
      else $error("pin sync leaked with software source");
   a_rdata_idle:
      assert property (!req.read |=> reg_rdata_out == 8'h00)
      else $error("read data outside read slot");

endmodule

// [test/sltc_rx_model.sv]
// link receiver model: raises sync on command, counts samples taken
`timescale 1ns/1ps
module sltc_rx_model (
   input  wire logic        sys_clk_in,
   input  wire logic        rst_b_in,
   input  wire logic        resync_in,
   input  wire logic        link_sample_valid_in,
   output logic             sync_n_out,
   output logic [15:0]      samples_seen_out
);
   logic        sync_n_next;
   logic [15:0] seen_next;
   always_comb begin
      // receiver holds sync low while not aligned
      sync_n_next = !resync_in;
      seen_next   = samples_seen_out + {15'h0000, link_sample_valid_in};
   end
   always_ff @(posedge sys_clk_in) begin
      if (!rst_b_in) begin
         sync_n_out       <= 1'b1;
         samples_seen_out <= 16'h0000;
      end else begin
         sync_n_out       <= sync_n_next;
         samples_seen_out <= seen_next;
      end
   end
endmodule

// [test/sltc_regs_test.sv]
// self-checking bench for the serial link transmit control registers
`timescale 1ns/1ps
module sltc_regs_test;
   import sltc_pkg::*;
   logic            clk, rst_b, wr, rd, cal, m64, dv, ts, sref, resync, lv, len, sreq, sal, sn;
   logic [11:0]     addr, din, fr;
   logic [7:0]      wd, rdat;
   logic [3:0]      me;
   logic [4:0]      mf;
   logic [15:0]     ldat;
   logic [15:0]     seen;
   logic [5:0]      mode;
   logic [1:0]      ila;
   sltc_link_ctrl_s lc;
   int              bad_count, n_tests, s, k;

   sltc_regs sltc_regs_i (.sys_clk_in(clk), .rst_b_in(rst_b), .reg_addr_in(addr),
      .reg_wdata_in(wd), .reg_write_in(wr), .reg_read_in(rd), .reg_rdata_out(rdat),
      .calibration_enable_in(cal), .mode_is_64b66b_in(m64), .mode_e_in(me), .mode_f_in(mf),
      .dedicated_sync_input_n_in(sn), .timestamp_input_pins_in(ts), .sysref_in(sref),
      .sample_valid_in(dv), .sample_data_in(din), .link_sample_valid_out(lv),
      .link_sample_data_out(ldat), .serial_link_enable_out(len), .link_ctrl_out(lc),
      .sysref_align_out(sal), .output_mode_select_out(mode), .frames_per_multiframe_out(fr),
      .ila_control_bits_out(ila), .sync_request_out(sreq));
   sltc_rx_model sltc_rx_model_i (.sys_clk_in(clk), .rst_b_in(rst_b), .resync_in(resync),
      .link_sample_valid_in(lv), .sync_n_out(sn), .samples_seen_out(seen));

   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string m);
      n_tests++;
      if (got !== exp) begin
         bad_count++;
         $display("[ERR] %0t %s got %h exp %h", $time, m, got, exp);
      end
   endtask
   task automatic wreg(input logic [11:0] a, input logic [7:0] d);
      @(posedge clk) begin wr <= 1'b1; addr <= a; wd <= d; end
      @(posedge clk) wr <= 1'b0;
      #1;
   endtask
   task automatic rreg(input logic [11:0] a, input logic [7:0] e);
      @(posedge clk) begin rd <= 1'b1; addr <= a; end
      @(posedge clk) rd <= 1'b0;
      #1 chk(rdat, e, "read");
      @(posedge clk) #1 chk(rdat, 8'h00, "rdata idle");
   endtask
   task automatic smp(input logic [11:0] d, input logic [15:0] e);
      @(posedge clk) begin dv <= 1'b1; din <= d; end
      @(posedge clk) dv <= 1'b0;
      #1 chk(ldat, e, "sample");
   endtask
   task automatic wait_n(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   // 256*e/f, zero for f of zero
   function automatic logic [15:0] eff_k(input int e, input int f);
      return (f == 0) ? 16'h0000 : 16'(256 * e / f);
   endfunction
   task automatic give_verdict;
      $display("comparisons %0d mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask

   initial begin
      {wr, rd, cal, m64, dv, ts, sref, resync} = '0;
      addr = '0; wd = '0; me = 4'h0; mf = 5'h00; din = '0; rst_b = 1'b0;
      bad_count = 0; n_tests = 0;
      void'($urandom(50409));
      repeat (4) @(posedge clk);
      rst_b <= 1'b1;
      rreg(OFFS_TS_LSB_CTRL, 8'h00);
      rreg(OFFS_LINK_ENABLE, 8'h01);
      rreg(OFFS_OUTPUT_MODE, 8'h00);
      rreg(OFFS_FRAMES_PER_MF, 8'h1f);
      rreg(OFFS_SW_SYNC, 8'h01);
      rreg(12'h3ff, 8'h00);
      chk(fr, 16'd32, "frames at reset");
      chk(ila, 2'h0, "ila bits");
      chk(lc, 4'ha, "link ctrl on");
      chk(len, 1'b1, "link enable at reset");
      chk(sreq, 1'b0, "sync idle");
      $display("test reset done");
      for (int i = 0; i < 8; i++) begin
         s = $urandom;
         smp(s[11:0], {s[11:0], 4'h0});
      end
      chk(lv, 1'b1, "valid on");
      cal <= 1'b1;
      wreg(OFFS_LINK_ENABLE, 8'h00);
      chk(lc, 4'h5, "link ctrl off");
      chk(len, 1'b0, "link enable off");
      smp(12'hfff, 16'h0000);
      chk(lv, 1'b0, "valid off");
      sref <= 1'b1;
      wait_n(4);
      chk(sal, 1'b0, "sysref held");
      cal <= 1'b0;
      for (int i = 0; i < 4; i++) begin
         s = $urandom;
         wreg(OFFS_OUTPUT_MODE, {2'h0, s[5:0]});
         chk(mode, s[5:0], "mode");
         wreg(OFFS_FRAMES_PER_MF, s[15:8]);
         wait_n(1);
         chk(fr, 16'(s[15:8]) + 16'd1, "frames");
         me <= 4'(s[19:16] | 4'h1);
         mf <= 5'(s[24:20] | 5'h01);
         m64 <= 1'b1;
         wait_n(2);
         chk(fr, eff_k(me, mf), "frames 64b66b");
         m64 <= 1'b0;
      end
      cal <= 1'b1;
      wreg(OFFS_LINK_ENABLE, 8'h01);
      wait_n(1);
      chk(sal, 1'b1, "sysref pass");
      $display("test link done");
      wreg(OFFS_SW_SYNC, 8'h00);
      chk(sreq, 1'b1, "sw sync");
      wreg(OFFS_SW_SYNC, 8'h01);
      chk(sreq, 1'b0, "sw sync off");
      resync <= 1'b1;
      wait_n(4);
      chk(sreq, 1'b1, "pin sync");
      wreg(OFFS_SYNC_CTRL, 8'h02);
      chk(sreq, 1'b0, "pin ignored");
      wreg(OFFS_SW_SYNC, 8'h00);
      chk(sreq, 1'b1, "sw sync sel 2");
      wreg(OFFS_SW_SYNC, 8'h01);
      resync <= 1'b0;
      wreg(OFFS_SYNC_CTRL, 8'h05);
      wait_n(4);
      chk(sreq, 1'b1, "ts pin sync");
      ts <= 1'b1;
      wreg(OFFS_TS_LSB_CTRL, 8'h01);
      wait_n(TS_DELAY_CYCLES + 4);
      chk(sreq, 1'b0, "ts pin idle");
      for (int i = 0; i < 4; i++) begin
         s = $urandom;
         smp(s[11:0], {s[11:0], 4'h1});
      end
      wait_n(1);
      chk(seen, 16'd12, "samples seen by receiver");
      $display("test sync done");
      give_verdict;
   end

   initial begin
      repeat (5000) @(posedge clk);
      bad_count++;
      give_verdict;
   end
endmodule
